/* File: sscs_core.sv */
// Purpose: serial clock source and shift-edge logic of an 8-bit synchronous port
// Assumes: clk is the high frequency clock; serialClockIn clocks the external link
// Notes: internal clock logic runs on clk, external clock logic on the link clock
`timescale 1ns/1ps
module sscs_core
  import sscs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic lowFreqClk,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serialClockIn,
  output logic serialClockOut,
  output logic serialClockOe,
  output logic serialOut,
  input wire logic serialIn
);

  ////////////////////////////////////////////////////////////////////////////
  // register file and bus slave
  logic ack_q;
  logic [31:0] rdat_q;
  logic [6:0] ctrl_q;
  logic [7:0] txBuf_q;
  logic txEmpty_q;
  logic [7:0] rxBuf_q;
  logic rxFull_q;
  logic access;
  logic wrLane0;
  logic ctrlWrite;
  logic txWrite;
  logic rxRead;
  logic [31:0] rdMux;
  logic [7:0] statusByte;
  logic start;
  logic [2:0] rateSel;
  logic tbLow;
  logic [1:0] pmode;
  logic lowMode;
  logic extMode;
  logic active;

  // decode of the current request; a write needs byte lane zero
  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign wrLane0 = access && wb_we_i && wb_sel_i[0];
  assign ctrlWrite = wrLane0 && (wb_adr_i == ADDR_CTRL);
  assign txWrite = wrLane0 && (wb_adr_i == ADDR_TXD);
  assign rxRead = access && !wb_we_i && (wb_adr_i == ADDR_RXD);
  assign start = ctrl_q[CTRL_START_BIT];
  assign rateSel = ctrl_q[CTRL_RATE_LSB +: 3];
  assign tbLow = ctrl_q[CTRL_TBLOW_BIT];
  assign pmode = ctrl_q[CTRL_PMODE_LSB +: 2];
  assign lowMode = (pmode == PM_LOW_RUN) || (pmode == PM_LOW_SLEEP);
  assign extMode = (rateSel == RATE_EXT);
  assign statusByte = {5'h00, rxFull_q, txEmpty_q, active};
  // unmapped offsets read zero and writes to them are dropped
  assign rdMux = (wb_adr_i == ADDR_CTRL) ? {25'h0000000, ctrl_q} :
                 (wb_adr_i == ADDR_STAT) ? {24'h000000, statusByte} :
                 (wb_adr_i == ADDR_RXD) ? {24'h000000, rxBuf_q} : 32'h00000000;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // one wait-free answer per request, ack falls the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      ctrl_q <= CTRL_RESET;
    end else begin
      ack_q <= access;
      rdat_q <= access ? rdMux : rdat_q;
      ctrl_q <= ctrlWrite ? wb_dat_i[6:0] : ctrl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock inputs and rate divider
  logic lowSync;
  logic lowSyncOld_q;
  logic lowEdge;
  logic serInSync;
  logic useLow;
  logic reservedCode;
  logic [3:0] halfLog;
  logic tick;
  logic divRun;
  sscs_state_e state_q;

  sscs_sync2 #(.W(1)) u_lowSync (.clk(clk), .rst(rst), .d(lowFreqClk), .q(lowSync));
  sscs_sync2 #(.W(1)) u_inSync (.clk(clk), .rst(rst), .d(serialIn), .q(serInSync));

  // slow source for code zero under the timebase select or a low-speed mode
  assign useLow = (rateSel == RATE_SLOWEST) && (tbLow || lowMode);
  assign reservedCode = lowMode && !useLow && !extMode;
  assign halfLog = useLow ? LOW_HALF_LOG : sscs_half_log(rateSel);
  assign lowEdge = lowSync && !lowSyncOld_q;
  assign divRun = (state_q == ST_LOAD) || (state_q == ST_LOW) || (state_q == ST_HIGH);

  always_ff @(posedge clk) begin
    if (rst) begin
      lowSyncOld_q <= 1'b0;
    end else begin
      lowSyncOld_q <= lowSync;
    end
  end

  sscs_rate_div #(.CW(11)) u_div (
    .clk(clk),
    .rst(rst),
    .run(divRun),
    .useLow(useLow),
    .lowEdge(lowEdge),
    .off(reservedCode),
    .halfLog(halfLog),
    .halfTick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // internal clock shift engine
  sscs_state_e state_d;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] rxSh_q;
  logic sckInt_q;
  logic sOutInt_q;
  logic canLoad;
  logic loadInt;
  logic depositInt;

  // a new byte may start once one is written; reserved codes never start
  assign canLoad = start && !extMode && !txEmpty_q && !reservedCode;
  assign loadInt = canLoad && ((state_q == ST_IDLE) || (state_q == ST_WAIT) ||
                   ((state_q == ST_DEPOSIT) && !rxFull_q));
  assign depositInt = (state_q == ST_DEPOSIT) && !rxFull_q;

  // next state: deposit stalls on an unread byte, wait stalls on a missing one
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: state_d = loadInt ? ST_LOAD : ST_IDLE;
      ST_LOAD: state_d = tick ? ST_LOW : ST_LOAD;
      ST_LOW: state_d = !tick ? ST_LOW :
                        (bitCnt_q == BITS_PER_BYTE - 4'h1) ? ST_DEPOSIT : ST_HIGH;
      ST_HIGH: state_d = tick ? ST_LOW : ST_HIGH;
      ST_DEPOSIT: state_d = rxFull_q ? ST_DEPOSIT : loadInt ? ST_LOAD :
                            start ? ST_WAIT : ST_IDLE;
      ST_WAIT: state_d = loadInt ? ST_LOAD : start ? ST_WAIT : ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // falling edge puts the next bit out, rising edge samples the input
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= IDLE_BYTE;
      rxSh_q <= 8'h00;
      sckInt_q <= 1'b1;
      sOutInt_q <= 1'b1;
    end else begin
      state_q <= state_d;
      if (loadInt) begin
        shift_q <= txBuf_q;
        bitCnt_q <= 4'h0;
      end else if (tick && (state_q != ST_LOW)) begin
        sckInt_q <= 1'b0;
        sOutInt_q <= shift_q[7];
        shift_q <= {shift_q[6:0], 1'b1};
      end else if (tick) begin
        sckInt_q <= 1'b1;
        rxSh_q <= {rxSh_q[6:0], serInSync};
        bitCnt_q <= bitCnt_q + 4'h1;
      end
      if (state_d == ST_IDLE) begin
        sOutInt_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external clock domain, clocked by the pin itself
  logic rstLink;
  logic txReqTgl_q;
  logic txPend_q;
  logic ackSeen_q;
  logic rxSeen_q;
  logic reqL;
  logic startL;
  logic takenTglN_q;
  logic busyN_q;
  logic outN_q;
  logic [3:0] cntN_q;
  logic [7:0] shN_q;
  logic [7:0] rxShP_q;
  logic [7:0] rxHoldP_q;
  logic [3:0] cntP_q;
  logic rxTglP_q;
  logic ackSync;
  logic rxSync;
  logic extSend;
  logic extAck;
  logic extRx;

  sscs_sync2 #(.W(1)) u_rstL (.clk(serialClockIn), .rst(1'b0), .d(rst), .q(rstLink));
  sscs_sync2 #(.W(2)) u_toLink (
    .clk(serialClockIn),
    .rst(rstLink),
    .d({txReqTgl_q, start && extMode}),
    .q({reqL, startL})
  );

  // leading edge: take a handed-over byte or shift the next bit out
  always_ff @(negedge serialClockIn) begin
    if (rstLink) begin
      takenTglN_q <= 1'b0;
      busyN_q <= 1'b0;
      outN_q <= 1'b1;
      cntN_q <= 4'h0;
      shN_q <= IDLE_BYTE;
    end else if (cntN_q != 4'h0) begin
      outN_q <= shN_q[7];
      shN_q <= {shN_q[6:0], 1'b1};
      cntN_q <= (cntN_q == BITS_PER_BYTE - 4'h1) ? 4'h0 : cntN_q + 4'h1;
    end else if (startL && (reqL != takenTglN_q)) begin
      outN_q <= txBuf_q[7];
      shN_q <= {txBuf_q[6:0], 1'b1};
      takenTglN_q <= !takenTglN_q;
      cntN_q <= 4'h1;
      busyN_q <= 1'b1;
    end else begin
      outN_q <= 1'b1;
      busyN_q <= 1'b0;
    end
  end

  // trailing edge: sample the input while a byte is running
  always_ff @(posedge serialClockIn) begin
    if (rstLink) begin
      rxShP_q <= 8'h00;
      rxHoldP_q <= 8'h00;
      cntP_q <= 4'h0;
      rxTglP_q <= 1'b0;
    end else if (busyN_q) begin
      rxShP_q <= {rxShP_q[6:0], serialIn};
      cntP_q <= (cntP_q == BITS_PER_BYTE - 4'h1) ? 4'h0 : cntP_q + 4'h1;
      if (cntP_q == BITS_PER_BYTE - 4'h1) begin
        rxHoldP_q <= {rxShP_q[6:0], serialIn};
        rxTglP_q <= !rxTglP_q;
      end
    end
  end

  sscs_sync2 #(.W(2)) u_toSys (
    .clk(clk),
    .rst(rst),
    .d({takenTglN_q, rxTglP_q}),
    .q({ackSync, rxSync})
  );

  // toggle handshake: the byte stays put in txBuf_q until the link returns the toggle
  assign extSend = start && extMode && !txEmpty_q && !txPend_q;
  assign extAck = ackSync != ackSeen_q;
  assign extRx = rxSync != rxSeen_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      txReqTgl_q <= 1'b0;
      txPend_q <= 1'b0;
      ackSeen_q <= 1'b0;
      rxSeen_q <= 1'b0;
    end else begin
      txReqTgl_q <= extSend ? !txReqTgl_q : txReqTgl_q;
      txPend_q <= extSend || (txPend_q && !extAck);
      ackSeen_q <= ackSync;
      rxSeen_q <= rxSync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffers, flags and pins
  // a set in the same cycle as a clear wins
  always_ff @(posedge clk) begin
    if (rst) begin
      txBuf_q <= IDLE_BYTE;
      txEmpty_q <= 1'b1;
      rxBuf_q <= 8'h00;
      rxFull_q <= 1'b0;
    end else begin
      txBuf_q <= (txWrite && txEmpty_q) ? wb_dat_i[7:0] : txBuf_q;
      txEmpty_q <= (loadInt || extAck) ? 1'b1 : txWrite ? 1'b0 : txEmpty_q;
      rxBuf_q <= depositInt ? rxSh_q : extRx ? rxHoldP_q : rxBuf_q;
      rxFull_q <= (depositInt || extRx) ? 1'b1 : rxRead ? 1'b0 : rxFull_q;
    end
  end

  // a taken byte stays busy until its eighth rising edge is reported back, so the flag
  // falls even though the pin clock stands still after the frame
  assign active = (state_q != ST_IDLE) || (ackSync != rxSync) || txPend_q;
  assign serialClockOe = !extMode;
  assign serialClockOut = sckInt_q;
  assign serialOut = extMode ? outN_q : sOutInt_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [11:0] gapCnt_q;
  logic gapValid_q;
  logic [12:0] resumeCnt_q;
  logic [11:0] halfCycles;

  assign halfCycles = 12'h001 << halfLog;

  always_ff @(posedge clk) begin
    if (rst || !divRun) begin
      gapCnt_q <= 12'h000;
      gapValid_q <= 1'b0;
    end else begin
      gapCnt_q <= tick ? 12'h000 : gapCnt_q + 12'h001;
      gapValid_q <= gapValid_q || tick;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || (state_q != ST_LOAD)) begin
      resumeCnt_q <= 13'h0000;
    end else begin
      resumeCnt_q <= resumeCnt_q + 13'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_idle_clk_high: assert property (state_q == ST_IDLE |-> serialClockOut)
    else $error("clock not high while idle");
  a_wait_clk_stop: assert property ((state_q == ST_WAIT || state_q == ST_DEPOSIT)
    ##1 (state_q == ST_WAIT || state_q == ST_DEPOSIT)
    |-> serialClockOut && $stable(serialClockOut))
    else $error("clock moved during automatic wait");
  a_resume_bound: assert property (!useLow |-> resumeCnt_q <= {halfCycles, 1'b0})
    else $error("clock resumed later than one period");
  a_drive_internal: assert property (state_q != ST_IDLE |-> serialClockOe)
    else $error("pin not driven during internal transfer");
  a_ext_no_drive: assert property (extMode |-> !serialClockOe && state_q == ST_IDLE)
    else $error("internal engine active in external mode");
  a_rate_gap: assert property (tick && gapValid_q && !useLow
    |-> gapCnt_q == halfCycles - 12'h001)
    else $error("half period differs from rate code");
  a_rate_reserved: assert property (reservedCode |-> !tick && state_q == ST_IDLE)
    else $error("reserved code produced a clock");
  a_fall_shift: assert property ($fell(sckInt_q) |-> sOutInt_q == $past(shift_q[7]))
    else $error("output bit not shifted on falling edge");
  a_rise_sample: assert property ($rose(sckInt_q) |-> rxSh_q[0] == $past(serInSync))
    else $error("input bit not sampled on rising edge");
  a_active_flag: assert property (state_q != ST_IDLE |-> statusByte[STAT_ACTIVE_BIT])
    else $error("active flag low during transfer");
  a_byte_count: assert property (state_q == ST_DEPOSIT |-> bitCnt_q == BITS_PER_BYTE)
    else $error("byte ended after wrong edge count");

  c_byte_done: cover property (depositInt);
  c_auto_wait: cover property (state_q == ST_DEPOSIT && rxFull_q ##1 state_q == ST_DEPOSIT);
  c_wait_resume: cover property (state_q == ST_WAIT ##1 state_q == ST_LOAD);
  c_ext_byte: cover property (extRx);

endmodule

/* File: sscs_peer.sv */
// Purpose: far-side serial device model for the serial clock and shift-edge block
// Assumes: bytes travel MSB first; the pin clock idles high
// Notes: the clock is made here only during reset and during external frames
`timescale 1ns/1ps
module sscs_peer (
  input wire logic rst,
  input wire logic sckPin,
  input wire logic sdi,
  output logic sdo,
  output logic sckDrv,
  output logic [7:0] rxByte,
  output logic done
);
  logic [7:0] txQ[$];
  logic [7:0] sh = 8'h00;
  logic inFrame = 1'b0;
  logic quiet = 1'b0;
  int cnt = 0;
  initial sdo = 1'b1;
  initial done = 1'b0;
  initial rxByte = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // two rising edges and two falling edges while reset is high, so the link side resets
  // before the bench hands the pin to the device; the clock then stands high
  initial begin
    sckDrv = 1'b0;
    #5 sckDrv = 1'b1;
    repeat (4) #40 sckDrv = ~sckDrv;
  end
  // two quiet clocks first: the pin-clocked link needs them to see start and byte
  // one byte of external clock follows, equal 40 ns phases, ending high
  task automatic extFrame();
    quiet = 1'b1;
    repeat (2) begin
      #40 sckDrv = 1'b0;
      #40 sckDrv = 1'b1;
    end
    repeat (8) begin
      #20 quiet = 1'b0;
      #20 sckDrv = 1'b0;
      #40 sckDrv = 1'b1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // a new bit leaves at each falling pin edge outside reset and quiet clocks, and holds across the rising edge
  always @(negedge sckPin) begin
    if (!rst && !quiet) begin
      if (!inFrame) begin
        sh = (txQ.size() > 0) ? txQ.pop_front() : 8'h00;
        inFrame = 1'b1;
      end
      sdo = sh[7];
      sh = {sh[6:0], 1'b0};
    end
  end
  // device bits taken at rising edges; data line turns over once the byte is done
  always @(posedge sckPin) begin
    if (!rst && inFrame) begin
      rxByte = {rxByte[6:0], sdi};
      cnt = cnt + 1;
      if (cnt == 8) begin
        cnt = 0;
        inFrame = 1'b0;
        done = 1'b1;
        #5 done = 1'b0;
        #245 sdo = ~sdo;
      end
    end
  end
endmodule

/* File: sscs_pkg.sv */
// Purpose: shared constants and types of the serial clock and shift-edge block
// Assumes: registers are reached over classic Wishbone with 32-bit data
// Notes: byte offsets, field positions, reset values and codes live here only
package sscs_pkg;

  // register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_TXD = 4'h8;
  localparam logic [3:0] ADDR_RXD = 4'hC;

  // control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RATE_LSB = 1;
  localparam int CTRL_TBLOW_BIT = 4;
  localparam int CTRL_PMODE_LSB = 5;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // status register fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_TXEMPTY_BIT = 1;
  localparam int STAT_RXFULL_BIT = 2;

  // rate codes and power modes
  localparam logic [2:0] RATE_SLOWEST = 3'h0;
  localparam logic [2:0] RATE_EXT = 3'h7;
  localparam logic [1:0] PM_HIGH_RUN = 2'h0;
  localparam logic [1:0] PM_HIGH_IDLE = 2'h1;
  localparam logic [1:0] PM_LOW_RUN = 2'h2;
  localparam logic [1:0] PM_LOW_SLEEP = 2'h3;

  // timing: low clock half period counts 2^3 low clock edges (divide by 2^4)
  localparam logic [3:0] LOW_HALF_LOG = 4'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_LOW = 3'b011,
    ST_HIGH = 3'b010,
    ST_DEPOSIT = 3'b110,
    ST_WAIT = 3'b111
  } sscs_state_e;

  // log2 of the half period in high clock cycles for an internal rate code
  function automatic logic [3:0] sscs_half_log(input logic [2:0] code);
    logic [3:0] r;
    r = 4'h2;
    case (code)
      3'h0: r = 4'hB;
      3'h1: r = 4'h7;
      3'h2: r = 4'h6;
      3'h3: r = 4'h5;
      3'h4: r = 4'h4;
      3'h5: r = 4'h3;
      default: r = 4'h2;
    endcase
    return r;
  endfunction

endpackage

/* File: sscs_rate_div.sv */
// Purpose: half-period tick generator for the internal serial clock
// Assumes: lowEdge is a one-cycle pulse per low clock rising edge
// Notes: the counter restarts whenever run drops, so a restart needs one half period
`timescale 1ns/1ps
module sscs_rate_div #(
  parameter int CW = 11
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic useLow,
  input wire logic lowEdge,
  input wire logic off,
  input wire logic [3:0] halfLog,
  output logic halfTick
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] mask;
  logic step;

  // step on every clk, or only on low clock edges when the slow source is chosen
  assign step = useLow ? lowEdge : 1'b1;
  assign mask = {{(CW-1){1'b0}}, 1'b1} << halfLog;
  assign halfTick = run && !off && step && ((cnt_q & (mask - 1'b1)) == (mask - 1'b1));

  // free counter, held at zero outside a run to fix the phase of the first edge
  always_ff @(posedge clk) begin
    if (rst || !run || off) begin
      cnt_q <= '0;
    end else if (step) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule

/* File: sscs_sync2.sv */
// Purpose: two flip-flop level synchroniser
// Assumes: d changes slowly relative to clk or is gray-safe per bit
// Notes: the first stage is read by the second stage only
`timescale 1ns/1ps
module sscs_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // metastability settles in meta_q before q is used
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

/* File: tb_top.sv */
// Purpose: self-checking bench for the serial clock and shift-edge block
// Assumes: classic Wishbone single cycles; far side modelled by sscs_peer
// Notes: half periods measured in clk cycles; low clock period is 1 us
`timescale 1ns/1ps
module tb_top;
  import sscs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic lowFreqClk = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic chkRd = 1'b0;
  logic [31:0] rdat, got;
  logic ack, sckOut, sckOe, sdOut, sdIn, sckDrv, sckPin, peerDone;
  logic [7:0] peerByte;
  logic [31:0] expRd[$];
  logic [7:0] expPeer[$];
  logic [7:0] rxExp[$];
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int n, c;
  // the device owns the pin except in code seven; the peer clocks the reset through
  assign sckPin = (sckOe && !rst) ? sckOut : sckDrv;
  initial forever #50 clk = ~clk;
  initial forever #500 lowFreqClk = ~lowFreqClk;
  sscs_core dut (.clk(clk), .rst(rst), .lowFreqClk(lowFreqClk), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .serialClockIn(sckPin), .serialClockOut(sckOut),
    .serialClockOe(sckOe), .serialOut(sdOut), .serialIn(sdIn));
  sscs_peer peer (.rst(rst), .sckPin(sckPin), .sdi(sdOut), .sdo(sdIn), .sckDrv(sckDrv),
    .rxByte(peerByte), .done(peerDone));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("mismatches=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a hang counts as a mismatch and closes the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fail_count++;
      end_sim();
    end
  end
  // results are matched against the oldest note as they appear
  always @(posedge clk) if (ack && !we && chkRd) check(rdat, expRd.pop_front());
  always @(posedge peerDone) check({24'h0, peerByte}, {24'h0, expPeer.pop_front()});
  ////////////////////////////////////////////////////////////////////////////////
  // one classic cycle; request held until ack is seen at a rising edge
  task automatic wbCyc(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic k, input logic [31:0] e);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    chkRd <= k;
    if (k) expRd.push_back(e);
    do @(posedge clk); while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chkRd <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wbCyc(1'b1, a, d, 4'hF, 1'b0, 32'h0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wbCyc(1'b0, a, 32'h0, 4'hF, 1'b1, e);
  endtask
  task automatic pollStat(input int b);
    do wbCyc(1'b0, ADDR_STAT, 32'h0, 4'hF, 1'b0, 32'h0); while (got[b] !== 1'b1);
  endtask
  task automatic sendByte(input logic [7:0] tx);
    logic [7:0] r;
    r = 8'($urandom);
    pollStat(STAT_TXEMPTY_BIT);
    peer.txQ.push_back(r);
    rxExp.push_back(r);
    expPeer.push_back(tx);
    wr(ADDR_TXD, {24'h0, tx});
  endtask
  task automatic recvByte();
    pollStat(STAT_RXFULL_BIT);
    rd(ADDR_RXD, {24'h0, rxExp.pop_front()});
  endtask
  // cycles until the driven clock reaches level v
  task automatic waitLvl(input logic v, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (sckOut !== v);
  endtask
  // counts low cycles of the driven clock over a stretch where it must stay high
  task automatic holdHigh();
    n = 0;
    repeat (100) begin
      @(posedge clk);
      n += (sckOut !== 1'b1);
    end
    check(32'(n), 32'h0);
  endtask
  // one internal byte: half period, active flag, data both ways, then idle
  task automatic intByte(input logic [6:0] ctl, input int half, input int tol);
    wr(ADDR_CTRL, {25'h0, ctl});
    check(32'(sckOe), 32'h1);
    sendByte(8'($urandom));
    waitLvl(1'b0, c);
    waitLvl(1'b1, c);
    check(32'((c - half) * (c - half) <= tol * tol), 32'h1);
    rd(ADDR_STAT, 32'h3);
    recvByte();
    wr(ADDR_CTRL, {25'h0, ctl & 7'h7E});
    rd(ADDR_STAT, 32'h2);
    check(32'(sckOut), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hF8D98F0D));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_STAT, 32'h2);
    rd(4'h2, 32'h0);
    check(32'(sckOut), 32'h1);
    wr(ADDR_CTRL, 32'h2A);
    wbCyc(1'b1, ADDR_CTRL, 32'h7F, 4'hE, 1'b0, 32'h0);
    rd(ADDR_CTRL, 32'h2A);
    for (int k = 6; k >= 0; k--) intByte(7'((k << 1) | 1), (k == 0) ? 2048 : (1 << (8 - k)), 0);
    intByte(7'h11, 80, 2);
    intByte(7'h41, 80, 2);
    intByte(7'h61, 80, 2);
    // waits: received byte left unread, then transmit byte missing
    wr(ADDR_CTRL, 32'hB);
    repeat (3) sendByte(8'($urandom));
    pollStat(STAT_RXFULL_BIT);
    repeat (200) @(posedge clk);
    holdHigh();
    recvByte();
    waitLvl(1'b0, c);
    check(32'(c <= 16), 32'h1);
    repeat (2) recvByte();
    holdHigh();
    sendByte(8'($urandom));
    waitLvl(1'b0, c);
    check(32'(c <= 16), 32'h1);
    recvByte();
    wr(ADDR_CTRL, 32'hA);
    rd(ADDR_STAT, 32'h2);
    // external clock from the peer
    wr(ADDR_CTRL, 32'hF);
    check(32'(sckOe), 32'h0);
    sendByte(8'($urandom));
    repeat (10) @(posedge clk);
    peer.extFrame();
    recvByte();
    wr(ADDR_CTRL, 32'hE);
    rd(ADDR_STAT, 32'h2);
    // reserved code in low-speed run: no clock at all
    wr(ADDR_CTRL, 32'h47);
    wr(ADDR_TXD, 32'h5A);
    holdHigh();
    end_sim();
  end
endmodule
